// [inc/cofg_pkg.sv]
package cofg_pkg;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_GAUGE = 32'h0000_0004;
  localparam logic [31:0] ADDR_COMMAND = 32'h0000_0008;
  localparam logic [31:0] ADDR_TARGET = 32'h0000_000c;
  localparam logic [31:0] ADDR_BALANCE = 32'h0000_0010;
  localparam logic [31:0] ADDR_OPTCFG = 32'h0000_0014;
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_RELEARN_BIT = 3;
  localparam int CMD_PROF_LSB = 4;
  localparam logic [2:0] CMD_CONT_ACTIVE = 3'h6;
  localparam logic [2:0] CMD_CONT_CHARGE = 3'h2;
  localparam logic [2:0] CMD_OD_ACTIVE = 3'h5;
  localparam logic [2:0] CMD_OD_CHARGE = 3'h1;
  localparam logic [5:0] PROF_RESET = 6'h01;
  localparam logic [3:0] TARGET_MIN = 4'h0;
  localparam logic [3:0] VCAPMAX_HI = 4'hf;
  localparam logic [3:0] VCAPMAX_LO = 4'hb;
  localparam logic [1:0] MARGIN_RESET = 2'h3;
  localparam int BAL_EN_BIT = 2;
  localparam int BAL_SEL_LSB = 0;
  localparam int BAL_PERIOD_US = 1000;
  localparam int CLK_MHZ = 20;
  localparam int BAL_CYCLES = BAL_PERIOD_US * CLK_MHZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NPROF = 64;
endpackage

// [inc/target_mem_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface target_mem_if;
  logic we;
  logic [5:0] waddr;
  logic [3:0] wdata;
  logic [5:0] raddr;
  logic [3:0] rdata;
  logic [5:0] clrAddr;
  logic clr;
  modport ctrl(output we, waddr, wdata, raddr, clr, clrAddr, input rdata);
  modport mem(input we, waddr, wdata, raddr, clr, clrAddr, output rdata);
endinterface
`default_nettype wire

// [rtl/target_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module target_mem (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] capMax,
  target_mem_if.mem port
);
  logic [3:0] store [0:cofg_pkg::NPROF-1];
  logic [cofg_pkg::NPROF-1:0] learned_ff;
  logic [3:0] rdata_ff;
  assign port.rdata = rdata_ff;
  always_ff @(posedge core_clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end
  // unlearned profiles start from the maximum target
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      learned_ff <= '0;
      rdata_ff <= 4'h0;
    end else begin
      if (port.we) begin
        learned_ff[port.waddr] <= 1'b1;
      end
      if (port.clr) begin
        learned_ff[port.clrAddr] <= 1'b0;
      end
      if (port.we && port.waddr == port.raddr) begin
        rdata_ff <= port.wdata;
      end else if (learned_ff[port.raddr] && !(port.clr && port.clrAddr == port.raddr)) begin
        rdata_ff <= store[port.raddr];
      end else begin
        rdata_ff <= capMax;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/charge_optimizer_fuel_gauge.sv]
// Operation
// - raise target stepwise when load grows
// - far below margin: raise two steps
// - moderately below margin: raise one step
// - at or just above margin: hold
// - neighbouring-level toggling is normal
// - count boost cycles while charging
// - each count is fixed charge
// - count held as 32-bit value
// - count readable in standby
// - continuous: clear on 6h to 2h
// - on-demand: clear on 5h to 1h
// - sample balance node every 1 ms
// - drive sink/source outside hysteresis window
// - balance needs enable; current from select
// - balance only at vcap >= 2 V
// - well above margin: lower one step
// - profile zero uses fixed target
// - relearn bit discards selected profile result
`timescale 1ns/1ns
`default_nettype none
module charge_optimizer_fuel_gauge (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chargeState,
  input wire logic standbyState,
  input wire logic boostCycle,
  input wire logic activeEnd,
  input wire logic [1:0] marginCmp,
  input wire logic balHigh,
  input wire logic balLow,
  input wire logic vcapAbove2v,
  output logic [3:0] chargeTarget,
  output logic balSink,
  output logic balSource,
  output logic [1:0] balCurrent
);
  // marginCmp: 0 far below, 1 moderately below, 2 at/just above, 3 well above
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRESP, BUS_RRESP} bus_t;
  typedef struct packed {
    bus_t bus;
    logic awDone;
    logic wDone;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic [7:0] command;
    logic [3:0] fixTarget;
    logic vcapmax;
    logic [1:0] margin;
    logic [2:0] balCfg;
    logic [31:0] gauge;
    logic [2:0] prevMode;
    logic [3:0] target;
    logic [$clog2(cofg_pkg::BAL_CYCLES)-1:0] balCnt;
    logic sink;
    logic source;
    logic relearnPend;
  } state_t;
  state_t cur_ff;
  state_t nxt_cur;
  target_mem_if mif();
  logic [3:0] capMax;
  logic [5:0] prof;
  logic [3:0] learned;

  function automatic logic [3:0] stepTarget(input logic [3:0] t, input logic [1:0] cmp, input logic [3:0] mx);
    logic [4:0] up;
    up = 5'h00;
    case (cmp)
      2'h0: up = {1'b0, t} + 5'h02;
      2'h1: up = {1'b0, t} + 5'h01;
      2'h3: up = (t == cofg_pkg::TARGET_MIN) ? {1'b0, t} : {1'b0, t} - 5'h01;
      default: up = {1'b0, t};
    endcase
    stepTarget = (up > {1'b0, mx}) ? mx : up[3:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  assign capMax = cur_ff.vcapmax ? cofg_pkg::VCAPMAX_HI : cofg_pkg::VCAPMAX_LO;
  assign prof = cur_ff.command[cofg_pkg::CMD_PROF_LSB +: 4] == 4'h0 ? 6'h00 : {2'h0, cur_ff.command[7:4]};
  assign learned = mif.rdata;
  assign mif.raddr = prof;

  target_mem u_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .capMax(capMax),
    .port(mif.mem)
  );

  always_comb begin
    logic [2:0] mode;
    logic [31:0] wd;
    nxt_cur = cur_ff;
    mode = cur_ff.command[cofg_pkg::CMD_MODE_LSB +: 3];
    wd = 32'h0000_0000;
    mif.we = 1'b0;
    mif.waddr = prof;
    mif.wdata = learned;
    mif.clr = 1'b0;
    mif.clrAddr = prof;
    // relearn request lives one cycle; a new command write re-arms it
    nxt_cur.relearnPend = 1'b0;
    // write channel: address and data accepted in either order
    if (s_axi_awvalid && !cur_ff.awDone && cur_ff.bus == BUS_IDLE) begin
      nxt_cur.awDone = 1'b1;
      nxt_cur.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur_ff.wDone && cur_ff.bus == BUS_IDLE) begin
      nxt_cur.wDone = 1'b1;
      nxt_cur.wData = s_axi_wdata;
      nxt_cur.wStrb = s_axi_wstrb;
    end
    if (cur_ff.bus == BUS_IDLE && cur_ff.awDone && cur_ff.wDone) begin
      nxt_cur.awDone = 1'b0;
      nxt_cur.wDone = 1'b0;
      nxt_cur.bus = BUS_WRESP;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = cofg_pkg::RESP_OKAY;
      case (cur_ff.awAddr[7:0])
        cofg_pkg::ADDR_COMMAND[7:0]: begin
          wd = merge({24'h0, cur_ff.command}, cur_ff.wData, cur_ff.wStrb);
          nxt_cur.command = wd[7:0] & 8'hf7;
          nxt_cur.relearnPend = wd[cofg_pkg::CMD_RELEARN_BIT];
        end
        cofg_pkg::ADDR_TARGET[7:0]: begin
          wd = merge({27'h0, cur_ff.vcapmax, cur_ff.fixTarget}, cur_ff.wData, cur_ff.wStrb);
          nxt_cur.fixTarget = wd[3:0];
          nxt_cur.vcapmax = wd[4];
        end
        cofg_pkg::ADDR_BALANCE[7:0]: begin
          wd = merge({29'h0, cur_ff.balCfg}, cur_ff.wData, cur_ff.wStrb);
          nxt_cur.balCfg = wd[2:0];
        end
        cofg_pkg::ADDR_OPTCFG[7:0]: begin
          wd = merge({30'h0, cur_ff.margin}, cur_ff.wData, cur_ff.wStrb);
          nxt_cur.margin = wd[1:0];
        end
        default: nxt_cur.bresp = cofg_pkg::RESP_SLVERR;
      endcase
      if (cur_ff.awAddr[31:8] != 24'h0) begin
        nxt_cur.bresp = cofg_pkg::RESP_SLVERR;
      end
    end
    if (cur_ff.bus == BUS_WRESP && s_axi_bready) begin
      nxt_cur.bvalid = 1'b0;
      nxt_cur.bus = BUS_IDLE;
    end
    if (cur_ff.bus == BUS_IDLE && !(cur_ff.awDone && cur_ff.wDone) && s_axi_arvalid) begin
      nxt_cur.bus = BUS_RRESP;
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp = cofg_pkg::RESP_OKAY;
      case (s_axi_araddr[7:0])
        cofg_pkg::ADDR_STATUS[7:0]: nxt_cur.rdata = {26'h0, cur_ff.source, cur_ff.sink, cur_ff.target};
        cofg_pkg::ADDR_GAUGE[7:0]: begin
          nxt_cur.rdata = cur_ff.gauge;
          if (!standbyState) begin
            nxt_cur.rresp = cofg_pkg::RESP_SLVERR;
          end
        end
        cofg_pkg::ADDR_COMMAND[7:0]: nxt_cur.rdata = {24'h0, cur_ff.command};
        cofg_pkg::ADDR_TARGET[7:0]: nxt_cur.rdata = {27'h0, cur_ff.vcapmax, cur_ff.fixTarget};
        cofg_pkg::ADDR_BALANCE[7:0]: nxt_cur.rdata = {29'h0, cur_ff.balCfg};
        cofg_pkg::ADDR_OPTCFG[7:0]: nxt_cur.rdata = {30'h0, cur_ff.margin};
        default: begin
          nxt_cur.rdata = 32'h0000_0000;
          nxt_cur.rresp = cofg_pkg::RESP_SLVERR;
        end
      endcase
      if (s_axi_araddr[31:8] != 24'h0) begin
        nxt_cur.rdata = 32'h0000_0000;
        nxt_cur.rresp = cofg_pkg::RESP_SLVERR;
      end
    end
    if (cur_ff.bus == BUS_RRESP && s_axi_rready) begin
      nxt_cur.rvalid = 1'b0;
      nxt_cur.bus = BUS_IDLE;
    end
    // optimizer
    if (cur_ff.relearnPend) begin
      mif.clr = 1'b1;
    end else if (activeEnd && prof != 6'h00) begin
      mif.we = 1'b1;
      mif.wdata = stepTarget(learned, marginCmp, capMax);
    end
    nxt_cur.target = (prof == 6'h00) ? cur_ff.fixTarget : learned;
    // fuel gauge
    nxt_cur.prevMode = mode;
    if ((cur_ff.prevMode == cofg_pkg::CMD_CONT_ACTIVE && mode == cofg_pkg::CMD_CONT_CHARGE) ||
        (cur_ff.prevMode == cofg_pkg::CMD_OD_ACTIVE && mode == cofg_pkg::CMD_OD_CHARGE)) begin
      nxt_cur.gauge = 32'h0000_0000;
    end else if (chargeState && boostCycle) begin
      nxt_cur.gauge = cur_ff.gauge + 32'h0000_0001;
    end
    // balancing
    if (!(chargeState && cur_ff.balCfg[cofg_pkg::BAL_EN_BIT] && vcapAbove2v)) begin
      nxt_cur.balCnt = '0;
      nxt_cur.sink = 1'b0;
      nxt_cur.source = 1'b0;
    end else if (cur_ff.balCnt == ($clog2(cofg_pkg::BAL_CYCLES))'(cofg_pkg::BAL_CYCLES - 1)) begin
      nxt_cur.balCnt = '0;
      nxt_cur.sink = balHigh;
      nxt_cur.source = balLow;
    end else begin
      nxt_cur.balCnt = cur_ff.balCnt + 1'b1;
    end
    // readies registered from the state the next cycle will hold
    nxt_cur.awRdy = nxt_cur.bus == BUS_IDLE && !nxt_cur.awDone;
    nxt_cur.wRdy = nxt_cur.bus == BUS_IDLE && !nxt_cur.wDone;
    nxt_cur.arRdy = nxt_cur.bus == BUS_IDLE && !(nxt_cur.awDone && nxt_cur.wDone);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.bus <= BUS_IDLE;
      cur_ff.awRdy <= 1'b1;
      cur_ff.wRdy <= 1'b1;
      cur_ff.arRdy <= 1'b1;
      cur_ff.command <= {cofg_pkg::PROF_RESET[3:0], 4'h0};
      cur_ff.margin <= cofg_pkg::MARGIN_RESET;
      cur_ff.prevMode <= 3'h0;
      cur_ff.gauge <= 32'h0000_0000;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign s_axi_awready = cur_ff.awRdy;
  assign s_axi_wready = cur_ff.wRdy;
  assign s_axi_arready = cur_ff.arRdy;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = cur_ff.rresp;
  assign chargeTarget = cur_ff.target;
  assign balSink = cur_ff.sink;
  assign balSource = cur_ff.source;
  assign balCurrent = cur_ff.balCfg[cofg_pkg::BAL_SEL_LSB +: 2];

  a_gauge_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!chargeState && !($past(cur_ff.prevMode) != cur_ff.prevMode)) |=> $stable(cur_ff.gauge) || cur_ff.gauge == 32'h0)
    else $error("gauge changed outside charge");
  a_gauge_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (chargeState && boostCycle && cur_ff.prevMode == nxt_cur.prevMode) |=> cur_ff.gauge == $past(cur_ff.gauge) + 32'h1)
    else $error("boost cycle not counted");
  a_gauge_cont: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cur_ff.prevMode == 3'h6 && cur_ff.command[2:0] == 3'h2) |=> cur_ff.gauge == 32'h0)
    else $error("continuous clear missed");
  a_gauge_od: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cur_ff.prevMode == 3'h5 && cur_ff.command[2:0] == 3'h1) |=> cur_ff.gauge == 32'h0)
    else $error("on-demand clear missed");
  a_bal_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!vcapAbove2v || !chargeState || !cur_ff.balCfg[2]) |=> !balSink && !balSource)
    else $error("balance active while gated");
  a_opt_twostep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (activeEnd && prof != 6'h0 && !cur_ff.relearnPend && marginCmp == 2'h0 && learned < 4'hd && capMax == 4'hf)
    |-> mif.wdata == learned + 4'h2)
    else $error("far-below step not two");
  a_opt_down: assert property (@(posedge core_clk) disable iff (!rst_n)
    (activeEnd && prof != 6'h0 && !cur_ff.relearnPend && marginCmp == 2'h3 && learned != 4'h0)
    |-> mif.wdata == learned - 4'h1)
    else $error("above-margin step not one down");
  a_opt_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (activeEnd && marginCmp == 2'h2) |-> mif.wdata == learned)
    else $error("target moved at margin");
  a_fix_target: assert property (@(posedge core_clk) disable iff (!rst_n)
    (prof == 6'h0) |=> chargeTarget == $past(cur_ff.fixTarget))
    else $error("profile zero not fixed target");
endmodule
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // address and data go out together; each drops at the edge it is taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge core_clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// [tb/charge_optimizer_fuel_gauge_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module charge_optimizer_fuel_gauge_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, chargeTarget;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, balSink, balSource;
  logic [1:0] bresp, rresp, balCurrent;
  logic chargeState = 1'b0;
  logic standbyState = 1'b1;
  logic boostCycle = 1'b0;
  logic activeEnd = 1'b0;
  logic [1:0] marginCmp = 2'h2;
  logic balHigh = 1'b0;
  logic balLow = 1'b0;
  logic vcapAbove2v = 1'b0;
  int nMismatch = 0;
  int nTests = 0;
  logic [1:0] ms [8] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2};
  logic [3:0] ex [8] = '{4'he, 4'hd, 4'hc, 4'hc, 4'he, 4'hf, 4'hf, 4'hf};
  always #25 core_clk = ~core_clk;
  host_model host (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  charge_optimizer_fuel_gauge dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chargeState(chargeState), .standbyState(standbyState),
    .boostCycle(boostCycle), .activeEnd(activeEnd), .marginCmp(marginCmp), .balHigh(balHigh),
    .balLow(balLow), .vcapAbove2v(vcapAbove2v), .chargeTarget(chargeTarget), .balSink(balSink),
    .balSource(balSource), .balCurrent(balCurrent));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk({30'h0, r}, {30'h0, cofg_pkg::RESP_OKAY});
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e, input logic err);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, err ? cofg_pkg::RESP_SLVERR : cofg_pkg::RESP_OKAY});
  endtask
  task automatic step(input logic [1:0] m);
    activeEnd <= 1'b1;
    marginCmp <= m;
    @(posedge core_clk);
    activeEnd <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic boost(input int n);
    repeat (n) begin
      boostCycle <= 1'b1;
      @(posedge core_clk);
      boostCycle <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task automatic waitSink(input logic e, input int lim);
    int k;
    k = 0;
    while (balSink !== e && k < lim) begin
      @(posedge core_clk);
      k++;
    end
  endtask
  task automatic wrap_up();
    if (nMismatch == 0 && nTests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rc(cofg_pkg::ADDR_GAUGE, 32'h0, 1'b0);
    rc(32'h0000_0040, 32'h0, 1'b1);
    w(cofg_pkg::ADDR_TARGET, 32'h15);
    w(cofg_pkg::ADDR_COMMAND, 32'h18);
    rc(cofg_pkg::ADDR_STATUS, 32'hf, 1'b0);
    for (int i = 0; i < 8; i++) begin
      step(ms[i]);
      rc(cofg_pkg::ADDR_STATUS, {28'h0, ex[i]}, 1'b0);
      chk({28'h0, chargeTarget}, {28'h0, ex[i]});
    end
    repeat (16) step(2'h3);
    rc(cofg_pkg::ADDR_STATUS, 32'h0, 1'b0);
    step(2'h0);
    rc(cofg_pkg::ADDR_STATUS, 32'h2, 1'b0);
    w(cofg_pkg::ADDR_COMMAND, 32'h00);
    rc(cofg_pkg::ADDR_STATUS, 32'h5, 1'b0);
    chk({28'h0, chargeTarget}, 32'h5);
    w(cofg_pkg::ADDR_COMMAND, 32'h16);
    w(cofg_pkg::ADDR_COMMAND, 32'h12);
    chargeState <= 1'b1;
    standbyState <= 1'b0;
    boost(5);
    rc(cofg_pkg::ADDR_GAUGE, 32'h5, 1'b1);
    chargeState <= 1'b0;
    boost(3);
    standbyState <= 1'b1;
    rc(cofg_pkg::ADDR_GAUGE, 32'h5, 1'b0);
    w(cofg_pkg::ADDR_COMMAND, 32'h16);
    w(cofg_pkg::ADDR_COMMAND, 32'h12);
    rc(cofg_pkg::ADDR_GAUGE, 32'h0, 1'b0);
    chargeState <= 1'b1;
    boost(4);
    chargeState <= 1'b0;
    rc(cofg_pkg::ADDR_GAUGE, 32'h4, 1'b0);
    w(cofg_pkg::ADDR_COMMAND, 32'h15);
    w(cofg_pkg::ADDR_COMMAND, 32'h11);
    rc(cofg_pkg::ADDR_GAUGE, 32'h0, 1'b0);
    w(cofg_pkg::ADDR_BALANCE, 32'h6);
    repeat (2) @(posedge core_clk);
    chk({30'h0, balCurrent}, 32'h2);
    chargeState <= 1'b1;
    balHigh <= 1'b1;
    vcapAbove2v <= 1'b1;
    waitSink(1'b1, 2 * cofg_pkg::BAL_CYCLES + 10);
    chk({31'h0, balSink}, 32'h1);
    chk({31'h0, balSource}, 32'h0);
    balHigh <= 1'b0;
    balLow <= 1'b1;
    waitSink(1'b0, cofg_pkg::BAL_CYCLES + 10);
    chk({31'h0, balSource}, 32'h1);
    vcapAbove2v <= 1'b0;
    waitSink(1'b0, cofg_pkg::BAL_CYCLES + 10);
    repeat (2) @(posedge core_clk);
    chk({31'h0, balSink}, 32'h0);
    chk({31'h0, balSource}, 32'h0);
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    nMismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
